// ==== verilog/spc_params.svh ====
/*
  Constants of the socket power and general pin block: strap bit positions,
  serial word layout, settle counts and link framing counts.
  Assumes it is included by bare name wherever a figure is needed.
*/
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH

// ****************************************************************
// Sockets and configuration
// ****************************************************************
`define SPC_SOCKETS        2
`define SPC_SPK_EN_BIT     4
`define SPC_LED_EN_BIT     2
`define SPC_DISK_LED_BIT   1

// ****************************************************************
// Strap register layout
// ****************************************************************
`define SPC_STRAP_SPK_BIT  0
`define SPC_STRAP_LED_BIT  1
`define SPC_STRAP_LAT_BIT  2
`define SPC_STRAP_DAT_BIT  3
`define SPC_STRAP_SUS_BIT  4
`define SPC_STRAP_W        5
`define SPC_STRAP_RST      5'h00
// Cycles after reset release before the straps are caught
`define SPC_STRAP_WAIT     3'h4

// ****************************************************************
// Power serial link
// ****************************************************************
`define SPC_REF_MIN_KHZ    10
`define SPC_REF_TYP_KHZ    32
`define SPC_REF_MAX_KHZ    100
`define SPC_PWR_WORD_W     8
`define SPC_SHIFT_LAST     4'h7
`define SPC_ACK_SLOT       4'h8
`define SPC_PH_LAST        2'h2
// Target address on the management bus, a plain default
`define SPC_SMB_ADDR       7'h2a

`endif

// ==== verilog/spc_pkg.sv ====
/*
  Types of the socket power and general pin block.
  Assumes spc_params.svh is on the include path.
*/
`include "spc_params.svh"

package spc_pkg;

  // ****************************************************************
  // Link sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_LATCH,
    ST_START,
    ST_BITS,
    ST_STOP,
    ST_DONE
  } spc_link_state_t;

  // ****************************************************************
  // Strap register, most significant field first
  // ****************************************************************
  typedef struct packed {
    logic suspend_sel;
    logic data;
    logic latch;
    logic led;
    logic speaker;
  } spc_strap_t;

  // ****************************************************************
  // One request to the power switch
  // ****************************************************************
  typedef struct packed {
    logic                         smbus;
    logic [`SPC_PWR_WORD_W-1:0]   word;
  } spc_req_t;

endpackage

// ==== verilog/spc_serial.sv ====
/*
  Power serial link sequencer, clocked by the power-serial reference clock.
  Assumes the request word is held stable from its toggle until the answer
  toggle returns, and that the reference clock runs while a request waits.
*/
`timescale 1ns/10ps
`include "spc_params.svh"

module spc_serial (
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_req_tgl,
  input  wire spc_pkg::spc_req_t i_req,
  output logic                   o_ack_tgl,
  output logic                   o_data,
  output logic                   o_data_oe_n,
  output logic                   o_latch,
  output logic                   o_latch_oe_n
);

  spc_pkg::spc_link_state_t   state;
  logic                       req_s1;
  logic                       req_s2;
  logic                       req_seen;
  logic                       smb;
  logic [`SPC_PWR_WORD_W-1:0] word;
  logic [3:0]                 bit_cnt;
  logic [1:0]                 ph;
  logic                       byte_sel;
  logic [`SPC_PWR_WORD_W-1:0] cur_byte;

  function automatic logic pick_bit(input logic [7:0] b,
                                    input logic [3:0] idx);
    pick_bit = b[3'h7 - idx[2:0]];
  endfunction

  assign cur_byte = byte_sel ? word : {`SPC_SMB_ADDR, 1'h0};

  // ****************************************************************
  // Request crossing
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_s1 <= 1'h0;
      req_s2 <= 1'h0;
    end else begin
      req_s1 <= i_req_tgl;
      req_s2 <= req_s1;
    end
  end

  // ****************************************************************
  // Sequencer, every step on a reference clock edge
  // ****************************************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= spc_pkg::ST_IDLE;
      req_seen  <= 1'h0;
      smb       <= 1'h0;
      word      <= '0;
      bit_cnt   <= 4'h0;
      ph        <= 2'h0;
      byte_sel  <= 1'h0;
      o_ack_tgl <= 1'h0;
    end else begin
      unique case (state)
        spc_pkg::ST_IDLE: begin
          if (req_s2 != req_seen) begin
            req_seen <= req_s2;
            smb      <= i_req.smbus;
            word     <= i_req.word;
            bit_cnt  <= 4'h0;
            ph       <= 2'h0;
            byte_sel <= 1'h0;
            state    <= i_req.smbus ? spc_pkg::ST_START
                                    : spc_pkg::ST_SHIFT;
          end
        end
        spc_pkg::ST_SHIFT: begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == `SPC_SHIFT_LAST) begin
            state <= spc_pkg::ST_LATCH;
          end
        end
        spc_pkg::ST_LATCH: state <= spc_pkg::ST_DONE;
        spc_pkg::ST_START: state <= spc_pkg::ST_BITS;
        spc_pkg::ST_BITS: begin
          ph <= (ph == `SPC_PH_LAST) ? 2'h0 : ph + 2'h1;
          if (ph == `SPC_PH_LAST) begin
            if (bit_cnt == `SPC_ACK_SLOT) begin
              bit_cnt  <= 4'h0;
              byte_sel <= 1'h1;
              if (byte_sel) begin
                state <= spc_pkg::ST_STOP;
              end
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        spc_pkg::ST_STOP: begin
          ph <= ph + 2'h1;
          if (ph == `SPC_PH_LAST) begin
            ph    <= 2'h0;
            state <= spc_pkg::ST_DONE;
          end
        end
        spc_pkg::ST_DONE: begin
          o_ack_tgl <= ~o_ack_tgl;
          state     <= spc_pkg::ST_IDLE;
        end
        default: state <= spc_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pins, one reference cycle behind the sequencer
  // ****************************************************************
  // Open-drain lines only ever pull low; a one is a released line
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data       <= 1'h0;
      o_data_oe_n  <= 1'h1;
      o_latch      <= 1'h0;
      o_latch_oe_n <= 1'h1;
    end else begin
      unique case (state)
        spc_pkg::ST_IDLE: begin
          if (smb) begin
            o_data       <= 1'h0;
            o_data_oe_n  <= 1'h1;
            o_latch      <= 1'h0;
            o_latch_oe_n <= 1'h1;
          end
        end
        spc_pkg::ST_SHIFT: begin
          o_data       <= pick_bit(word, bit_cnt);
          o_data_oe_n  <= 1'h0;
          o_latch      <= 1'h0;
          o_latch_oe_n <= 1'h0;
        end
        spc_pkg::ST_LATCH: o_latch <= 1'h1;
        spc_pkg::ST_START: begin
          o_data       <= 1'h0;
          o_data_oe_n  <= 1'h0;
          o_latch      <= 1'h0;
          o_latch_oe_n <= 1'h1;
        end
        spc_pkg::ST_BITS: begin
          if (ph == 2'h0) begin
            o_latch_oe_n <= 1'h0;
          end else if (ph == 2'h1) begin
            o_data_oe_n <= (bit_cnt == `SPC_ACK_SLOT) ||
                           pick_bit(cur_byte, bit_cnt);
          end else begin
            o_latch_oe_n <= 1'h1;
          end
        end
        spc_pkg::ST_STOP: begin
          if (ph == 2'h0) begin
            o_latch_oe_n <= 1'h0;
          end else if (ph == 2'h1) begin
            o_data_oe_n <= 1'h0;
          end else begin
            o_latch_oe_n <= 1'h1;
          end
        end
        spc_pkg::ST_DONE: begin
          if (smb) begin
            o_data_oe_n <= 1'h1;
          end else begin
            o_latch <= 1'h0;
          end
        end
        default: o_latch <= 1'h0;
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_LATCH_ONE_CYCLE: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    ($rose(o_latch) && !smb) |=> !o_latch)
    else $error("latch pulse longer than one reference cycle");

  AST_LATCH_AFTER_SHIFT: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_latch) |-> $past(state) == spc_pkg::ST_LATCH &&
                       $past(state, 2) == spc_pkg::ST_SHIFT)
    else $error("latch raised without a finished shift");

  AST_DATA_SHIFTED: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    state == spc_pkg::ST_SHIFT |=>
      !o_data_oe_n && o_data == $past(word[3'h7 - bit_cnt[2:0]]))
    else $error("serial data bit not driven");

  AST_SMB_DATA_OD: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (smb && state != spc_pkg::ST_IDLE) |=> !o_data)
    else $error("bus data driven high");

  AST_SMB_CLK_OD: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (smb && state != spc_pkg::ST_IDLE) |=> !o_latch)
    else $error("bus clock driven high");

  AST_SMB_START: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    state == spc_pkg::ST_START |=> o_latch_oe_n && !o_data_oe_n)
    else $error("start condition malformed");

endmodule

// ==== verilog/spc_gen_pins.sv ====
/*
  General interface and power-control pins of a card-socket controller:
  speaker and activity outputs, suspend input, reset straps and the link
  to the socket power switch.
  Assumes pins resolve outside from output enables, pull-ups hold released
  lines high and configuration inputs come from logic on i_mclk.
*/
// What this block does
// - Speaker pin driven only for enabled socket
// - Activity pin driven only when LED enabled
// - Socket counts as disk activity when enabled
// - Suspend select turns activity pin into input
// - Reset samples speaker and activity pins
// - Reset samples link data and latch pins
// - Link timed by reference clock input
// - Three-wire mode drives serial data out
// - Three-wire mode pulses latch after word
// - Bus mode data is open drain
// - Bus mode clock is open drain
// - Each socket input speaker or disk LED
`timescale 1ns/10ps
`include "spc_params.svh"

module spc_gen_pins (
  input  wire logic                      i_mclk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_ref_clk,
  input  wire logic [`SPC_SOCKETS-1:0]   i_socket_audio_led_input,
  input  wire logic [`SPC_SOCKETS-1:0]   i_speaker_enable,
  input  wire logic [`SPC_SOCKETS-1:0]   i_disk_interface_config_led,
  input  wire logic                      i_led_enable,
  input  wire logic                      i_suspend_select,
  input  wire logic                      i_smbus_mode,
  input  wire logic [`SPC_PWR_WORD_W-1:0] i_power_word,
  input  wire logic                      i_power_write,
  input  wire logic                      i_speaker_out_pin,
  input  wire logic                      i_activity_led_pin,
  input  wire logic                      i_power_serial_data,
  input  wire logic                      i_power_serial_latch,
  output logic                           o_speaker_out_pin,
  output logic                           o_speaker_out_pin_oe_n,
  output logic                           o_activity_led_pin,
  output logic                           o_activity_led_pin_oe_n,
  output logic                           o_power_serial_data,
  output logic                           o_power_serial_data_oe_n,
  output logic                           o_power_serial_latch,
  output logic                           o_power_serial_latch_oe_n,
  output logic                           o_n_input_a,
  output spc_pkg::spc_strap_t            o_strap_config,
  output logic                           o_strap_valid,
  output logic                           o_power_busy
);

  // Pin levels come from outside i_mclk; two flops stand before any
  // logic reads them, and the strap wait covers that delay
  logic [`SPC_SOCKETS-1:0] aud_s1;
  logic [`SPC_SOCKETS-1:0] aud_s2;
  logic [3:0]              pin_s1;
  logic [3:0]              pin_s2;
  logic [2:0]              wait_cnt;
  logic                    strap_take;
  logic                    spk_routed;
  logic                    disk_active;
  spc_pkg::spc_req_t       req_q;
  logic                    req_tgl;
  logic                    ack_tgl;
  logic                    ack_s1;
  logic                    ack_s2;
  logic                    ack_seen;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      aud_s1 <= '0;
      aud_s2 <= '0;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      aud_s1 <= i_socket_audio_led_input;
      aud_s2 <= aud_s1;
      pin_s1 <= {i_power_serial_data, i_power_serial_latch,
                 i_activity_led_pin, i_speaker_out_pin};
      pin_s2 <= pin_s1;
    end
  end

  // ****************************************************************
  // Reset straps
  // ****************************************************************
  // Pins stay released until the straps are caught, so the pull-ups
  // and strap resistors alone set the sampled levels
  assign strap_take = !o_strap_valid && (wait_cnt == `SPC_STRAP_WAIT);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt      <= 3'h0;
      o_strap_valid <= 1'h0;
    end else if (strap_take) begin
      o_strap_valid <= 1'h1;
    end else if (!o_strap_valid) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_strap_config <= `SPC_STRAP_RST;
    end else begin
      o_strap_config.suspend_sel <= i_suspend_select;
      if (strap_take) begin
        o_strap_config.speaker <= pin_s2[0];
        o_strap_config.led     <= pin_s2[1];
        o_strap_config.latch   <= pin_s2[2];
        o_strap_config.data    <= pin_s2[3];
      end
    end
  end

  // ****************************************************************
  // Speaker routing
  // ****************************************************************
  // Several enabled sockets are merged; software normally enables one
  assign spk_routed = |(i_speaker_enable & aud_s2);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_speaker_out_pin      <= 1'h0;
      o_speaker_out_pin_oe_n <= 1'h1;
    end else begin
      o_speaker_out_pin_oe_n <= !(o_strap_valid &&
                                  (|i_speaker_enable));
      o_speaker_out_pin      <= spk_routed;
    end
  end

  // ****************************************************************
  // Activity LED and suspend input
  // ****************************************************************
  // Socket input is active low; a low on an enabled socket is activity
  assign disk_active = |(i_disk_interface_config_led & ~aud_s2);

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_activity_led_pin      <= 1'h0;
      o_activity_led_pin_oe_n <= 1'h1;
    end else begin
      // Written bit gates at once; its mirror lags one cycle and
      // would let the pin drive while it turns into an input
      o_activity_led_pin_oe_n <= !(o_strap_valid && i_led_enable &&
                                   !i_suspend_select &&
                                   !o_strap_config.suspend_sel);
      o_activity_led_pin      <= disk_active;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_n_input_a <= 1'h1;
    end else begin
      o_n_input_a <= o_strap_config.suspend_sel ? pin_s2[1] : 1'h1;
    end
  end

  // ****************************************************************
  // Power switch requests, toggle handshake to the link clock
  // ****************************************************************
  // The word is held in req_q until the answer returns, so the link
  // side may read it as a stable bus
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_s1 <= 1'h0;
      ack_s2 <= 1'h0;
    end else begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_q        <= '0;
      req_tgl      <= 1'h0;
      ack_seen     <= 1'h0;
      o_power_busy <= 1'h0;
    end else if (!o_power_busy && i_power_write && o_strap_valid) begin
      req_q.smbus  <= i_smbus_mode;
      req_q.word   <= i_power_word;
      req_tgl      <= ~req_tgl;
      o_power_busy <= 1'h1;
    end else if (ack_s2 != ack_seen) begin
      ack_seen     <= ack_s2;
      o_power_busy <= 1'h0;
    end
  end

  // A write while busy is dropped without notice; software polls
  // o_power_busy first, since a queue would cost a buffer
  spc_serial u_link (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_req_tgl    (req_tgl),
    .i_req        (req_q),
    .o_ack_tgl    (ack_tgl),
    .o_data       (o_power_serial_data),
    .o_data_oe_n  (o_power_serial_data_oe_n),
    .o_latch      (o_power_serial_latch),
    .o_latch_oe_n (o_power_serial_latch_oe_n)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  AST_SPK_GATED: assert property (
    !o_speaker_out_pin_oe_n |-> $past(|i_speaker_enable) &&
                                $past(o_strap_valid))
    else $error("speaker pin driven with no socket enabled");

  AST_SPK_FOLLOWS: assert property (
    ##1 !o_speaker_out_pin_oe_n |->
      o_speaker_out_pin == $past(|(i_speaker_enable & aud_s2)))
    else $error("speaker pin does not follow routed socket");

  AST_LED_GATED: assert property (
    !o_activity_led_pin_oe_n |-> $past(i_led_enable))
    else $error("activity pin driven while disabled");

  AST_LED_DISK: assert property (
    (!o_activity_led_pin_oe_n && o_activity_led_pin) |->
      $past(|(i_disk_interface_config_led & ~aud_s2)))
    else $error("activity shown without enabled disk socket");

  AST_SUSPEND_INPUT: assert property (
    o_strap_config.suspend_sel |=> o_activity_led_pin_oe_n &&
                                   o_n_input_a == $past(pin_s2[1]))
    else $error("activity pin not an input in suspend mode");

  AST_STRAP_SPK_LED: assert property (
    $rose(o_strap_valid) |->
      o_strap_config.speaker == $past(pin_s2[0]) &&
      o_strap_config.led == $past(pin_s2[1]) &&
      $past(o_speaker_out_pin_oe_n) && $past(o_activity_led_pin_oe_n))
    else $error("speaker or activity strap mis-sampled");

  AST_STRAP_LINK: assert property (
    $rose(o_strap_valid) |->
      o_strap_config.latch == $past(pin_s2[2]) &&
      o_strap_config.data == $past(pin_s2[3]) &&
      $past(o_power_serial_data_oe_n) &&
      $past(o_power_serial_latch_oe_n))
    else $error("link strap mis-sampled");

  AST_STRAP_HELD: assert property (
    o_strap_valid |=> $stable(o_strap_config[`SPC_STRAP_DAT_BIT:0]))
    else $error("strap bits changed after capture");

  AST_REQ_AFTER_STRAP: assert property (
    $rose(o_power_busy) |-> o_strap_valid && $changed(req_tgl))
    else $error("request issued before straps were caught");

  // The link clock reads the word, so it must not move while busy
  AST_REQ_STABLE: assert property (
    o_power_busy |=> $stable(req_q))
    else $error("request word changed while busy");

  // Straps read released pins; nothing may drive before capture
  AST_PINS_RELEASED: assert property (
    !o_strap_valid |-> o_speaker_out_pin_oe_n &&
                       o_activity_led_pin_oe_n &&
                       o_power_serial_data_oe_n &&
                       o_power_serial_latch_oe_n)
    else $error("pin driven before straps were caught");

  AST_STRAP_ONCE: assert property (
    o_strap_valid |=> o_strap_valid)
    else $error("strap capture lost before reset");

  AST_LED_SUSPEND_OFF: assert property (
    i_suspend_select |=> o_activity_led_pin_oe_n)
    else $error("activity pin driven after suspend select");

  AST_N_INPUT_IDLE: assert property (
    !o_strap_config.suspend_sel |=> o_n_input_a)
    else $error("suspend input active while not selected");

  // Covers for the main scenarios that the bench walks
  COV_SPEAKER: cover property (
    !o_speaker_out_pin_oe_n ##1 $changed(o_speaker_out_pin));
  COV_LED: cover property (!o_activity_led_pin_oe_n && o_activity_led_pin);
  COV_SUSPEND: cover property (o_strap_config.suspend_sel && !o_n_input_a);
  COV_TRANSFER: cover property ($fell(o_power_busy));
  COV_STRAP: cover property ($rose(o_strap_valid));

endmodule

// ==== verification/spc_pwr_model.sv ====
/*
  Behavioural power switch on the far side of the power serial link.
  Assumes the bench says which mode the link is in and supplies the
  pull levels that hold released lines.
*/
`timescale 1ns/10ps

module spc_pwr_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_smbus_mode,
  input  wire logic       i_pull_data,
  input  wire logic       i_pull_latch,
  input  wire logic       i_data,
  input  wire logic       i_data_oe_n,
  input  wire logic       i_latch,
  input  wire logic       i_latch_oe_n,
  output logic            o_data_line,
  output logic            o_latch_line,
  output logic [7:0]      o_word,
  output logic [7:0]      o_addr,
  output logic [7:0]      o_words
);
  logic [7:0]  tw_sreg = 8'h00;
  logic [18:0] sm_sreg = 19'h0;
  logic [7:0]  tw_word, sm_word;
  logic [7:0]  tw_cnt = 8'h00, sm_cnt = 8'h00;
  assign o_word  = i_smbus_mode ? sm_word : tw_word;
  assign o_words = tw_cnt + sm_cnt;
  // ****************************************************************
  // Line resolution
  // ****************************************************************
  // Released lines fall to their pull, never to the last level
  assign o_data_line  = !i_data_oe_n ? i_data : i_pull_data;
  assign o_latch_line = !i_latch_oe_n ? i_latch : i_pull_latch;
  // ****************************************************************
  // Word capture
  // ****************************************************************
  always @(negedge i_ref_clk) begin
    if (!i_smbus_mode && !o_latch_line) begin
      tw_sreg <= {tw_sreg[6:0], o_data_line};
    end
  end
  always @(posedge o_latch_line) begin
    if (i_smbus_mode) begin
      sm_sreg <= {sm_sreg[17:0], o_data_line};
    end else if (!i_latch_oe_n) begin
      tw_word <= tw_sreg;
      tw_cnt  <= tw_cnt + 8'h01;
    end
  end
  // Stop adds one clock rise, so the frame sits one place up
  always @(posedge o_data_line) begin
    if (i_smbus_mode && o_latch_line) begin
      o_addr  <= sm_sreg[18:11];
      sm_word <= sm_sreg[9:2];
      sm_cnt  <= sm_cnt + 8'h01;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
/*
  Self-checking bench of the general pins block.
  Assumes the design files and spc_pwr_model are compiled first.
*/
`timescale 1ns/10ps
`include "spc_params.svh"
`define TB_CHK(nm, ex, got) begin \
  checks_done++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); \
  end \
end

module tb_top;
  logic mclk = 1'b0, ref_clk = 1'b0, rst_n = 1'b0, led_en = 1'b0;
  logic sus_sel = 1'b0, smb = 1'b0, wr = 1'b0;
  logic [1:0] aud = 2'h3, spk_en = 2'h0, disk = 2'h0;
  logic [7:0] pword = 8'h00, mword, maddr, words;
  logic [3:0] pulls = 4'h0;
  logic spk_o, spk_oe_n, led_o, led_oe_n, dat_o, dat_oe_n, lat_o;
  logic lat_oe_n, n_in_a, strap_ok, busy, dat_line, lat_line;
  spc_pkg::spc_strap_t strap;
  int err_total = 0, checks_done = 0;
  logic [10:0] rows [8] = '{11'h035, 11'h258, 11'h260, 11'h429,
                            11'h6ea, 11'h156, 11'h164, 11'h085};
  wire spk_line = !spk_oe_n ? spk_o : pulls[0];
  wire led_line = !led_oe_n ? led_o : pulls[1];

  always #2 mclk = ~mclk;
  always #15 ref_clk = ~ref_clk;

  spc_gen_pins i_spc_gen_pins (.i_mclk(mclk), .i_rst_n(rst_n),
    .i_ref_clk(ref_clk), .i_socket_audio_led_input(aud),
    .i_speaker_enable(spk_en), .i_disk_interface_config_led(disk),
    .i_led_enable(led_en), .i_suspend_select(sus_sel),
    .i_smbus_mode(smb), .i_power_word(pword), .i_power_write(wr),
    .i_speaker_out_pin(spk_line), .i_activity_led_pin(led_line),
    .i_power_serial_data(dat_line), .i_power_serial_latch(lat_line),
    .o_speaker_out_pin(spk_o), .o_speaker_out_pin_oe_n(spk_oe_n),
    .o_activity_led_pin(led_o), .o_activity_led_pin_oe_n(led_oe_n),
    .o_power_serial_data(dat_o), .o_power_serial_data_oe_n(dat_oe_n),
    .o_power_serial_latch(lat_o), .o_power_serial_latch_oe_n(lat_oe_n),
    .o_n_input_a(n_in_a), .o_strap_config(strap),
    .o_strap_valid(strap_ok), .o_power_busy(busy));

  spc_pwr_model i_spc_pwr_model (.i_ref_clk(ref_clk), .i_smbus_mode(smb),
    .i_pull_data(pulls[3]), .i_pull_latch(pulls[2]), .i_data(dat_o),
    .i_data_oe_n(dat_oe_n), .i_latch(lat_o), .i_latch_oe_n(lat_oe_n),
    .o_data_line(dat_line), .o_latch_line(lat_line), .o_word(mword),
    .o_addr(maddr), .o_words(words));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Pulls stand in for strap resistors while the pins are released
  task automatic reset_dut(input logic [3:0] p);
    int i;
    pulls <= p;
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    `TB_CHK("oe_n", 4'hf, {spk_oe_n, led_oe_n, dat_oe_n, lat_oe_n})
    rst_n <= 1'b1;
    for (i = 0; i < 10 && strap_ok !== 1'b1; i++) @(posedge mclk);
    #1;
    `TB_CHK("strap", {1'b1, p}, {strap_ok, strap[3:0]})
    pulls <= 4'hf;
  endtask

  // A second write while busy must be dropped
  task automatic pwr(input logic [7:0] w, input logic m);
    int i;
    logic [7:0] n;
    n = words;
    @(posedge mclk);
    smb <= m;
    pword <= w;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    pword <= 8'h11;
    @(posedge mclk);
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
    `TB_CHK("busy", 1'b1, busy)
    for (i = 0; i < 5000 && busy !== 1'b0; i++) begin
      @(posedge mclk);
      #1;
    end
    `TB_CHK("words", n + 8'h01, words)
    `TB_CHK("word", w, mword)
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    reset_dut(4'ha);
    foreach (rows[k]) begin
      @(posedge mclk);
      {spk_en, disk, led_en, aud} <= rows[k][10:4];
      repeat (6) @(posedge mclk);
      #1;
      `TB_CHK("spk_oe_n", rows[k][2], spk_oe_n)
      if (!rows[k][2]) `TB_CHK("spk", rows[k][3], spk_o)
      `TB_CHK("led_oe_n", rows[k][0], led_oe_n)
      if (!rows[k][0]) `TB_CHK("led", rows[k][1], led_o)
    end
    @(posedge mclk);
    sus_sel <= 1'b1;
    led_en <= 1'b1;
    pulls[1] <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    `TB_CHK("sus", 3'h6, {strap.suspend_sel, led_oe_n, n_in_a})
    sus_sel <= 1'b0;
    pulls[1] <= 1'b1;
    pwr(8'hc5, 1'b0);
    `TB_CHK("dat_oe_n", 1'b0, dat_oe_n)
    pwr(8'h3c, 1'b1);
    `TB_CHK("addr", {`SPC_SMB_ADDR, 1'b0}, maddr)
    `TB_CHK("od", 2'h0, {dat_o, lat_o})
    reset_dut(4'h5);
    finish_test();
  end

  initial begin
    #100000;
    err_total++;
    finish_test();
  end
endmodule
